// ---- verification/pdd_regs_tb_top.sv ----
// Self-checking bench for the drive, delay and discharge register bank
`timescale 1ns/10ps
`include "pdd_params.svh"
module pdd_regs_tb_top
    import pdd_pkg::*;
;
    logic          clk;
    logic          resetn;
    logic          power_resetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [15:0]   paddr;
    logic [31:0]   pwdata;
    logic [3:0]    pstrb;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          mac_esd_hit;
    logic          line_esd_hit;
    pdd_drive_type drive;
    logic          irq;
    int            fail_count;
    int            tests_run;
    int            cyc;
    int            seed;

    localparam logic [15:0] A_FINE = {`PDD_IDX_FINE, 2'b00};
    localparam logic [15:0] A_CRS  = {`PDD_IDX_COARSE, 2'b00};
    localparam logic [15:0] A_DLY  = {`PDD_IDX_DELAY, 2'b00};
    localparam logic [15:0] A_ESD  = {`PDD_IDX_ESD, 2'b00};
    localparam logic [15:0] A_STAT = {`PDD_IDX_STAT, 2'b00};
    localparam logic [15:0] A_MASK = {`PDD_IDX_MASK, 2'b00};

    pdd_regs dut (
        .clk          (clk),
        .resetn       (resetn),
        .power_resetn (power_resetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .pstrb        (pstrb),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .mac_esd_hit  (mac_esd_hit),
        .line_esd_hit (line_esd_hit),
        .drive        (drive),
        .irq          (irq)
    );

    // ----------------------------------------------------------------
    // Clock and hang guard
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is about five hundred cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Request held from setup until pready is seen high at an access edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the cycle ceiling ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic hits(input bit ln, input int n);
        @(posedge clk);
        if (ln) line_esd_hit <= 1'b1;
        else mac_esd_hit <= 1'b1;
        repeat (n) @(posedge clk);
        line_esd_hit <= 1'b0;
        mac_esd_hit  <= 1'b0;
    endtask : hits

    function automatic logic [31:0] fpct(input int c);
        return {24'h0, 8'(2 * c - 16)};
    endfunction : fpct

    function automatic logic [31:0] cpct(input int c);
        return {24'h0, 8'(20 * c - 60)};
    endfunction : cpct

    function automatic logic [31:0] dps(input int c);
        return {20'h0, 12'((c + 1) * 250)};
    endfunction : dps

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [31:0] wd;
        logic        e;
        int          nm;
        int          nl;
        seed = 14581;
        {resetn, power_resetn, psel, penable, pwrite, mac_esd_hit, line_esd_hit} = '0;
        paddr  = '0;
        pwdata = '0;
        pstrb  = 4'hF;
        repeat (3) @(posedge clk);
        resetn       <= 1'b1;
        power_resetn <= 1'b1;
        apb(0, A_FINE, 0, q, e);
        chk(q, 32'h0000000A);
        chk({31'h0, e}, 32'h0);
        apb(0, A_CRS, 0, q, e);
        chk(q, 32'h00000383);
        apb(0, A_DLY, 0, q, e);
        chk(q, 32'h00000077);
        apb(0, A_ESD, 0, q, e);
        chk(q, 32'h00000000);
        apb(0, A_STAT, 0, q, e);
        chk(q, 32'h00000000);
        chk({20'h0, drive.tx_ps}, 32'h000007D0);
        chk({20'h0, drive.rx_ps}, 32'h000007D0);
        for (int c = 0; c < 16; c++) begin
            wd = $random(seed);
            apb(1, A_FINE, {wd[31:4], 4'(c)}, q, e);
            apb(0, A_FINE, 0, q, e);
            chk(q, {16'h0, wd[15:4], 4'(c)});
            apb(1, A_CRS, {wd[31:3], 3'(c)}, q, e);
            apb(1, A_DLY, {wd[31:8], 4'(c), 4'(15 - c)}, q, e);
            apb(0, A_DLY, 0, q, e);
            chk(q, {24'h0, 4'(c), 4'(15 - c)});
            @(posedge clk);
            #1;
            chk({28'h0, drive.fine_code}, 32'(c));
            chk({24'h0, drive.fine_pct}, fpct(c));
            chk({29'h0, drive.coarse_code}, 32'(c % 8));
            chk({24'h0, drive.coarse_pct}, cpct(c % 8));
            chk({28'h0, drive.tx_code}, 32'(c));
            chk({20'h0, drive.tx_ps}, dps(c));
            chk({28'h0, drive.rx_code}, 32'(15 - c));
            chk({20'h0, drive.rx_ps}, dps(15 - c));
        end
        // Unmapped place errors, counter register ignores writes
        apb(0, 16'h1200, 0, q, e);
        chk({31'h0, e}, 32'h1);
        apb(1, A_ESD, 32'hFFFFFFFF, q, e);
        chk({31'h0, e}, 32'h0);
        apb(0, A_ESD, 0, q, e);
        chk(q, 32'h0);
        nm = 1 + ($unsigned($random(seed)) % 20);
        nl = 1 + ($unsigned($random(seed)) % 20);
        hits(0, nm);
        hits(1, nl);
        apb(0, A_ESD, 0, q, e);
        chk(q, 32'(nm << 8) | 32'(nl));
        apb(0, A_STAT, 0, q, e);
        chk(q, 32'h3);
        #1;
        chk({31'h0, irq}, 32'h0);
        apb(1, A_MASK, 32'h1, q, e);
        #1;
        chk({31'h0, irq}, 32'h1);
        apb(1, A_STAT, 32'h1, q, e);
        #1;
        chk({31'h0, irq}, 32'h0);
        apb(1, A_MASK, 32'h2, q, e);
        #1;
        chk({31'h0, irq}, 32'h1);
        apb(1, A_STAT, 32'h2, q, e);
        apb(0, A_STAT, 0, q, e);
        chk(q, 32'h0);
        #1;
        chk({31'h0, irq}, 32'h0);
        // counters survive hardware reset, settings do not
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        apb(0, A_ESD, 0, q, e);
        chk(q, 32'(nm << 8) | 32'(nl));
        apb(0, A_FINE, 0, q, e);
        chk(q, 32'h0000000A);
        // both counters hold at their top value, MAC hits unmasked
        apb(1, A_MASK, 32'h1, q, e);
        hits(0, 70);
        hits(1, 70);
        apb(0, A_ESD, 0, q, e);
        chk(q, 32'h00003F3F);
        apb(0, A_STAT, 0, q, e);
        chk(q, 32'hF);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        power_resetn <= 1'b0;
        @(posedge clk);
        power_resetn <= 1'b1;
        apb(0, A_ESD, 0, q, e);
        chk(q, 32'h0);
        end_sim();
    end
endmodule : pdd_regs_tb_top

// ---- verilog/pdd_params.svh ----
// Offsets, field positions and reset values of the drive, delay and discharge registers
//
// Function
// - The fine swing code is four bits, resets to 1010, and sets gain from -16% at 0000 in 2% steps, 1000 unchanged.
// - The coarse swing code is three bits, resets to 011 (unchanged), and steps gain by 20% from -60% to +80%.
// - The transmit clock delay code is four bits, resets to 0111, and delays by (code+1) x 0.25 ns.
// - The receive clock delay code is a separate four bits with the same encoding and reset 0111.
// - A read-only six-bit counter in bits 13:8 counts discharge hits on the MAC-side interface pins.
// - A read-only six-bit counter in bits 5:0 counts discharge hits on the line pins.
// - Counting has no dead time, so one discharge pulse may count more than once.
// - Both counters survive the hardware reset and clear only on a power cycle.
// - Bits 15:8 of the delay control register read as zero and cannot be written.
`ifndef PDD_PARAMS_SVH
`define PDD_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PDD_IDX_FINE     14'h0401
`define PDD_IDX_COARSE   14'h0402
`define PDD_IDX_DELAY    14'h0446
`define PDD_IDX_ESD      14'h0448
`define PDD_IDX_STAT     14'h0449
`define PDD_IDX_MASK     14'h044A

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDD_FINE_RST     16'h000A
`define PDD_COARSE_RST   16'h0383
`define PDD_DELAY_RST    8'h77
`define PDD_STAT_RST     4'h0

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define PDD_TX_LSB       4
`define PDD_ESD_MAC_LSB  8
`define PDD_ESD_W        6
`define PDD_ST_MAC       0
`define PDD_ST_LINE      1
`define PDD_ST_MAC_SAT   2
`define PDD_ST_LINE_SAT  3
`define PDD_ST_W         4

// ----------------------------------------------------------------
// Encoding steps
// ----------------------------------------------------------------
`define PDD_DELAY_STEP_PS 12'h0FA
`define PDD_FINE_BASE     8'h10
`define PDD_COARSE_STEP   8'h14
`define PDD_COARSE_BASE   8'h3C

`endif

// ---- verilog/pdd_pkg.sv ----
// Types shared by the drive, delay and discharge register bank
package pdd_pkg;

    // ----------------------------------------------------------------
    // Register select
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PDD_SEL_NONE   = 3'b000,
        PDD_SEL_FINE   = 3'b001,
        PDD_SEL_COARSE = 3'b010,
        PDD_SEL_DELAY  = 3'b011,
        PDD_SEL_ESD    = 3'b100,
        PDD_SEL_STAT   = 3'b101,
        PDD_SEL_MASK   = 3'b110
    } pdd_sel_type;

    // ----------------------------------------------------------------
    // Settings handed to the analog driver and the delay line
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0]        fine_code;
        logic signed [7:0] fine_pct;
        logic [2:0]        coarse_code;
        logic signed [7:0] coarse_pct;
        logic [3:0]        tx_code;
        logic [11:0]       tx_ps;
        logic [3:0]        rx_code;
        logic [11:0]       rx_ps;
    } pdd_drive_type;

endpackage : pdd_pkg

// ---- verilog/pdd_regs.sv ----
// APB register bank for line-driver swing, clock-path delay and discharge counters
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "pdd_params.svh"
module pdd_regs
    import pdd_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                power_resetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                mac_esd_hit,
    input  wire logic                line_esd_hit,
    output pdd_drive_type            drive,
    output logic                     irq
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic pdd_sel_type sel_of(input logic [ADDR_W-1:0] a);
        logic [13:0] idx;
        idx = 14'(a[ADDR_W-1:2]);
        case (idx)
            `PDD_IDX_FINE:   sel_of = PDD_SEL_FINE;
            `PDD_IDX_COARSE: sel_of = PDD_SEL_COARSE;
            `PDD_IDX_DELAY:  sel_of = PDD_SEL_DELAY;
            `PDD_IDX_ESD:    sel_of = PDD_SEL_ESD;
            `PDD_IDX_STAT:   sel_of = PDD_SEL_STAT;
            `PDD_IDX_MASK:   sel_of = PDD_SEL_MASK;
            default:         sel_of = PDD_SEL_NONE;
        endcase
    endfunction : sel_of

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        merge16 = old;
        if (st[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (st[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction : merge16

    function automatic logic [11:0] delay_ps(input logic [3:0] code);
        delay_ps = 12'(({8'h00, code} + 12'h001) * `PDD_DELAY_STEP_PS);
    endfunction : delay_ps

    function automatic logic signed [7:0] fine_pct(input logic [3:0] code);
        fine_pct = signed'(8'({3'b000, code, 1'b0} - `PDD_FINE_BASE));
    endfunction : fine_pct

    function automatic logic signed [7:0] coarse_pct(input logic [2:0] code);
        coarse_pct = signed'(8'({5'h00, code} * `PDD_COARSE_STEP - `PDD_COARSE_BASE));
    endfunction : coarse_pct

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    pdd_sel_type sel;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_en;
    logic        err;

    assign sel       = sel_of(paddr);
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign err       = (sel == PDD_SEL_NONE);
    assign wr_en     = access_ph && pwrite && !err;
    // Zero wait states: read data were captured in the setup cycle
    assign pready    = 1'b1;
    assign pslverr   = access_ph && err;

    // ----------------------------------------------------------------
    // Discharge counters
    // ----------------------------------------------------------------
    logic [`PDD_ESD_W-1:0] mac_cnt;
    logic [`PDD_ESD_W-1:0] line_cnt;
    logic                  mac_max;
    logic                  line_max;

    pdd_sat_counter #(.W(`PDD_ESD_W)) u_mac_cnt (
        .clk          (clk),
        .power_resetn (power_resetn),
        .hit          (mac_esd_hit),
        .count        (mac_cnt),
        .at_max       (mac_max)
    );

    pdd_sat_counter #(.W(`PDD_ESD_W)) u_line_cnt (
        .clk          (clk),
        .power_resetn (power_resetn),
        .hit          (line_esd_hit),
        .count        (line_cnt),
        .at_max       (line_max)
    );

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [15:0]           fine_r;
    logic [15:0]           fine_nxt;
    logic [15:0]           coarse_r;
    logic [15:0]           coarse_nxt;
    logic [7:0]            dly_r;
    logic [7:0]            dly_nxt;
    logic [`PDD_ST_W-1:0]  stat_r;
    logic [`PDD_ST_W-1:0]  stat_nxt;
    logic [`PDD_ST_W-1:0]  mask_r;
    logic [`PDD_ST_W-1:0]  mask_nxt;
    logic [`PDD_ST_W-1:0]  ev;
    pdd_drive_type         drive_r;
    pdd_drive_type         drive_nxt;

    // Decoded reset settings derive from the register reset words
    localparam logic [15:0] FINE_RST_V   = `PDD_FINE_RST;
    localparam logic [15:0] COARSE_RST_V = `PDD_COARSE_RST;
    localparam logic [7:0]  DELAY_RST_V  = `PDD_DELAY_RST;

    assign ev[`PDD_ST_MAC]      = mac_esd_hit;
    assign ev[`PDD_ST_LINE]     = line_esd_hit;
    assign ev[`PDD_ST_MAC_SAT]  = mac_esd_hit && mac_max;
    assign ev[`PDD_ST_LINE_SAT] = line_esd_hit && line_max;

    always_comb begin
        fine_nxt   = fine_r;
        coarse_nxt = coarse_r;
        dly_nxt    = dly_r;
        mask_nxt   = mask_r;
        stat_nxt   = stat_r;
        if (wr_en && sel == PDD_SEL_FINE) begin
            fine_nxt = merge16(fine_r, pwdata, pstrb);
        end
        if (wr_en && sel == PDD_SEL_COARSE) begin
            coarse_nxt = merge16(coarse_r, pwdata, pstrb);
        end
        if (wr_en && sel == PDD_SEL_DELAY && pstrb[0]) begin
            dly_nxt = pwdata[7:0];
        end
        if (wr_en && sel == PDD_SEL_MASK && pstrb[0]) begin
            mask_nxt = pwdata[`PDD_ST_W-1:0];
        end
        if (wr_en && sel == PDD_SEL_STAT && pstrb[0]) begin
            stat_nxt = stat_r & ~pwdata[`PDD_ST_W-1:0];
        end
        // A new event wins over a write-one clear in the same cycle
        stat_nxt = stat_nxt | ev;
    end

    always_comb begin
        drive_nxt.fine_code   = fine_nxt[3:0];
        drive_nxt.fine_pct    = fine_pct(fine_nxt[3:0]);
        drive_nxt.coarse_code = coarse_nxt[2:0];
        drive_nxt.coarse_pct  = coarse_pct(coarse_nxt[2:0]);
        drive_nxt.tx_code     = dly_nxt[7:`PDD_TX_LSB];
        drive_nxt.tx_ps       = delay_ps(dly_nxt[7:`PDD_TX_LSB]);
        drive_nxt.rx_code     = dly_nxt[3:0];
        drive_nxt.rx_ps       = delay_ps(dly_nxt[3:0]);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fine_r                <= `PDD_FINE_RST;
            coarse_r              <= `PDD_COARSE_RST;
            dly_r                 <= `PDD_DELAY_RST;
            stat_r                <= `PDD_STAT_RST;
            mask_r                <= `PDD_STAT_RST;
            drive_r.fine_code     <= FINE_RST_V[3:0];
            drive_r.fine_pct      <= fine_pct(FINE_RST_V[3:0]);
            drive_r.coarse_code   <= COARSE_RST_V[2:0];
            drive_r.coarse_pct    <= coarse_pct(COARSE_RST_V[2:0]);
            drive_r.tx_code       <= DELAY_RST_V[7:`PDD_TX_LSB];
            drive_r.tx_ps         <= delay_ps(DELAY_RST_V[7:`PDD_TX_LSB]);
            drive_r.rx_code       <= DELAY_RST_V[3:0];
            drive_r.rx_ps         <= delay_ps(DELAY_RST_V[3:0]);
        end else begin
            fine_r   <= fine_nxt;
            coarse_r <= coarse_nxt;
            dly_r    <= dly_nxt;
            stat_r   <= stat_nxt;
            mask_r   <= mask_nxt;
            drive_r  <= drive_nxt;
        end
    end

    assign drive = drive_r;
    assign irq   = |(stat_r & mask_r);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] rd_val;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (sel)
            PDD_SEL_FINE:   rd_val[15:0] = fine_r;
            PDD_SEL_COARSE: rd_val[15:0] = coarse_r;
            PDD_SEL_DELAY:  rd_val[7:0]  = dly_r;
            PDD_SEL_ESD: begin
                rd_val[`PDD_ESD_MAC_LSB +: `PDD_ESD_W] = mac_cnt;
                rd_val[`PDD_ESD_W-1:0]                = line_cnt;
            end
            PDD_SEL_STAT:   rd_val[`PDD_ST_W-1:0] = stat_r;
            PDD_SEL_MASK:   rd_val[`PDD_ST_W-1:0] = mask_r;
            PDD_SEL_NONE:   rd_val = 32'h0000_0000;
        endcase
        prdata_nxt = prdata_r;
        if (setup_ph && !pwrite) begin
            prdata_nxt = rd_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic       dly_wr;
    logic [3:0] wr_tx;
    logic [3:0] wr_rx;
    logic       dly_rd;

    assign dly_wr = wr_en && sel == PDD_SEL_DELAY && pstrb[0];
    assign wr_tx  = pwdata[7:4];
    assign wr_rx  = pwdata[3:0];
    assign dly_rd = access_ph && !pwrite && sel == PDD_SEL_DELAY;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_fine_reset_value: assert property (
        $rose(resetn) |-> drive.fine_code == 4'hA && drive.fine_pct == 8'sd4)
        else $error("fine swing reset value wrong");

    a_coarse_reset_value: assert property (
        $rose(resetn) |-> drive.coarse_code == 3'h3 && drive.coarse_pct == 8'sd0)
        else $error("coarse swing reset value wrong");

    a_tx_delay_write: assert property (
        dly_wr |=> drive.tx_code == $past(wr_tx)
                && drive.tx_ps == 12'(({8'h00, drive.tx_code} + 12'h001) * 12'h0FA))
        else $error("transmit delay does not follow write");

    a_rx_delay_write: assert property (
        dly_wr |=> drive.rx_code == $past(wr_rx)
                && drive.rx_ps == 12'(({8'h00, drive.rx_code} + 12'h001) * 12'h0FA))
        else $error("receive delay does not follow write");

    a_mac_count_step: assert property (
        mac_esd_hit && !mac_max |=> mac_cnt == $past(mac_cnt) + 6'h01)
        else $error("MAC-side counter missed a hit");

    a_line_count_step: assert property (
        line_esd_hit && !line_max |=> line_cnt == $past(line_cnt) + 6'h01)
        else $error("line-side counter missed a hit");

    a_count_no_debounce: assert property (
        (mac_esd_hit && mac_cnt < 6'h3C) ##1 mac_esd_hit [*2]
            |=> mac_cnt == $past(mac_cnt, 3) + 6'h03)
        else $error("held hit not counted every cycle");

    a_count_survive_reset: assert property (
        @(posedge clk) disable iff (!power_resetn)
        !resetn |=> line_cnt >= $past(line_cnt) && mac_cnt >= $past(mac_cnt))
        else $error("counter lost by hardware reset");

    a_count_saturate: assert property (
        @(posedge clk) disable iff (!power_resetn)
        mac_cnt == 6'h3F |=> mac_cnt == 6'h3F)
        else $error("counter wrapped past maximum");

    a_delay_upper_zero: assert property (
        dly_rd |-> prdata[31:8] == 24'h00_0000 && prdata[7:0] == dly_r)
        else $error("delay register upper byte not zero");

    a_fine_code_write: assert property (
        wr_en && sel == PDD_SEL_FINE && pstrb[0]
            |=> drive.fine_code == $past(pwdata[3:0]))
        else $error("fine swing code does not follow write");

    a_coarse_code_write: assert property (
        wr_en && sel == PDD_SEL_COARSE && pstrb[0]
            |=> drive.coarse_code == $past(pwdata[2:0]))
        else $error("coarse swing code does not follow write");

    a_esd_read_layout: assert property (
        setup_ph && !pwrite && sel == PDD_SEL_ESD
            |=> prdata == {18'h00000, $past(mac_cnt), 2'b00, $past(line_cnt)})
        else $error("discharge counter read layout wrong");

    a_line_saturate: assert property (
        @(posedge clk) disable iff (!power_resetn)
        line_cnt == 6'h3F |=> line_cnt == 6'h3F)
        else $error("line-side counter wrapped past maximum");

    a_irq_follows_event: assert property (
        mac_esd_hit && mask_r[`PDD_ST_MAC] |=> irq)
        else $error("unmasked event did not raise interrupt");

    c_delay_write: cover property (dly_wr ##1 drive.tx_ps == 12'hFA0);
    c_mac_saturate: cover property (mac_esd_hit && mac_max);
    c_irq_rise: cover property ($rose(irq));
    c_esd_read: cover property (access_ph && !pwrite && sel == PDD_SEL_ESD);

endmodule : pdd_regs

// ---- verilog/pdd_sat_counter.sv ----
// Saturating event counter cleared only by the power-on reset
`timescale 1ns/10ps
`include "pdd_params.svh"
module pdd_sat_counter #(
    parameter int W = `PDD_ESD_W
) (
    input  wire logic         clk,
    input  wire logic         power_resetn,
    input  wire logic         hit,
    output logic [W-1:0]      count,
    output logic              at_max
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // ----------------------------------------------------------------
    // Next count
    // ----------------------------------------------------------------
    always_comb begin
        count_nxt = count_r;
        // every active cycle, held at top
        // No dead time: a hit held for several cycles counts each one
        if (hit && !(&count_r)) begin
            count_nxt = count_r + W'(1);
        end
    end

    // power reset only
    // The hardware reset is deliberately not wired here
    always_ff @(posedge clk) begin
        if (!power_resetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign at_max = &count_r;
    assign count  = count_r;

endmodule : pdd_sat_counter
